//--- include/boot_ctrl_pkg.sv
// package for the reset and boot stall controller
// assumes a single 50 MHz core clock
package boot_ctrl_pkg;

    // =========================================================
    // boot mode strap encodings
    localparam logic [1:0] MODE_HOST = 2'h0;
    localparam logic [1:0] MODE_EMU  = 2'h1;
    localparam logic [1:0] MODE_ROM  = 2'h2;

    // =========================================================
    // boot copy geometry and addresses
    localparam int          ROM_COPY_BYTES = 1024;
    localparam logic [31:0] CPU_START_ADDR = 32'h0000_0000;
    localparam logic [31:0] ROM_BASE_ADDR  = 32'h9000_0000;
    localparam logic [31:0] COPY_DST_ADDR  = 32'h0000_0000;

    // rom width codes
    localparam logic [1:0] ROM_W8  = 2'h0;
    localparam logic [1:0] ROM_W16 = 2'h1;
    localparam logic [1:0] ROM_W32 = 2'h2;

    // =========================================================
    // controller states
    typedef enum logic [4:0] {
        ST_RESET = 5'h01,
        ST_STALL = 5'h02,
        ST_COPY  = 5'h04,
        ST_WAIT  = 5'h08,
        ST_RUN   = 5'h10
    } boot_state_e;

endpackage : boot_ctrl_pkg

//--- logic/rom_word_packer.sv
// packs narrow rom beats into 32-bit instruction words
// assumes beats arrive on the core clock, one per valid cycle
`timescale 1ns/10ps
module rom_word_packer
    import boot_ctrl_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        clear,
    input  wire logic [1:0]  rom_width,
    input  wire logic        beat_valid,
    input  wire logic [31:0] beat_data,
    output logic             word_valid,
    output logic [31:0]      word_data
);

    // =========================================================
    // assembly state
    logic [31:0] acc_reg;
    logic [31:0] acc_next;
    logic [1:0]  cnt_reg;
    logic [1:0]  cnt_next;
    logic        vld_reg;
    logic        vld_next;

    function automatic logic [1:0] last_beat(input logic [1:0] w);
        case (w)
            ROM_W8:  last_beat = 2'h3;
            ROM_W16: last_beat = 2'h1;
            default: last_beat = 2'h0;
        endcase
    endfunction : last_beat

    // little-endian placement: first beat lands in the low lane
    always_comb
    begin
        acc_next = acc_reg;
        cnt_next = cnt_reg;
        vld_next = 1'b0;
        if (clear)
        begin
            cnt_next = 2'h0;
        end
        else if (beat_valid)
        begin
            case (rom_width)
                ROM_W8:  acc_next[cnt_reg*8 +: 8] = beat_data[7:0];
                ROM_W16: acc_next[cnt_reg[0]*16 +: 16] = beat_data[15:0];
                default: acc_next = beat_data;
            endcase
            if (cnt_reg == last_beat(rom_width))
            begin
                cnt_next = 2'h0;
                vld_next = 1'b1;
            end
            else
            begin
                cnt_next = 2'(cnt_reg + 2'h1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_reg <= 32'h0000_0000;
            cnt_reg <= 2'h0;
            vld_reg <= 1'b0;
        end
        else
        begin
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
            vld_reg <= vld_next;
        end
    end

    assign word_valid = vld_reg;
    assign word_data  = acc_reg;

endmodule : rom_word_packer

//--- logic/boot_stall_ctrl.sv
// reset and boot stall controller
// assumes straps are board levels; host port and copy engine on core_clk
// Function
// - reset input low holds internal reset
// - reset release starts selected boot mode
// - three modes: host, emulation, rom
// - host boot: cpu stalled, rest released
// - host writes memory during stall
// - host may read back memory
// - doorbell frees cpu at address 0
// - boot doorbell not a cpu interrupt
// - doorbell frees cpu in host and emulation modes, not rom
// - cpu clears doorbell before next accepted
// - emulation: emulator doorbell, breakpoint at 0
// - rom boot copies rom start to 0
// - narrow rom packed into 32-bit words
// - copy done frees cpu at 0
`timescale 1ns/10ps
module boot_stall_ctrl
    import boot_ctrl_pkg::*;
#(
    parameter int COPY_BYTES = ROM_COPY_BYTES
)
(
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    input  wire logic [1:0]  boot_mode_pin,
    input  wire logic [1:0]  rom_width_pin,
    input  wire logic        host_doorbell_set,
    input  wire logic        cpu_doorbell_clear,
    input  wire logic        host_mem_req,
    input  wire logic        emu_doorbell_set,
    input  wire logic        copy_ready,
    input  wire logic        rom_beat_valid,
    input  wire logic [31:0] rom_beat_data,
    output logic             periph_rst_n,
    output logic             cpu_stall,
    output logic             cpu_start,
    output logic [31:0]      cpu_start_addr,
    output logic             host_doorbell,
    output logic             cpu_doorbell_irq,
    output logic             host_mem_grant,
    output logic             copy_req,
    output logic [31:0]      copy_src_addr,
    output logic [31:0]      copy_dst_addr,
    output logic [31:0]      copy_word,
    output logic             copy_word_valid,
    output logic [1:0]       latched_mode
);

    localparam int WORDS = COPY_BYTES / 4;
    localparam int WW    = $clog2(WORDS + 1);

    // =========================================================
    // reset synchroniser
    logic rs1_reg;
    logic rs2_reg;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rs1_reg <= 1'b0;
            rs2_reg <= 1'b0;
        end
        else
        begin
            rs1_reg <= 1'b1;
            rs2_reg <= rs1_reg;
        end
    end
    wire rst_n = rs2_reg;

    // =========================================================
    // strap and doorbell synchronisers (external pins)
    logic [4:0] pin1_reg;
    logic [4:0] pin2_reg;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin1_reg <= 5'h00;
            pin2_reg <= 5'h00;
        end
        else
        begin
            pin1_reg <= {emu_doorbell_set, boot_mode_pin, rom_width_pin};
            pin2_reg <= pin1_reg;
        end
    end
    wire emu_set_s = pin2_reg[4];

    // =========================================================
    // state machine
    boot_state_e st_reg;
    boot_state_e st_next;
    logic [1:0]  mode_reg;
    logic [1:0]  mode_next;
    logic [1:0]  wid_reg;
    logic [1:0]  wid_next;
    logic        db_reg;
    logic        db_next;
    logic        irq_reg;
    logic        irq_next;
    logic [WW-1:0] wcnt_reg;
    logic [WW-1:0] wcnt_next;
    logic        start_reg;
    logic        start_next;
    logic        pk_valid;
    logic [31:0] pk_data;

    // doorbell accepted only while clear
    wire db_event = (host_doorbell_set | emu_set_s) & ~db_reg;

    always_comb
    begin
        st_next    = st_reg;
        mode_next  = mode_reg;
        wid_next   = wid_reg;
        wcnt_next  = wcnt_reg;
        start_next = 1'b0;
        irq_next   = irq_reg;
        db_next    = db_reg;
        if (db_event)
        begin
            db_next = 1'b1;
        end
        else if (cpu_doorbell_clear)
        begin
            db_next = 1'b0;
        end
        if (cpu_doorbell_clear)
        begin
            irq_next = 1'b0;
        end
        case (st_reg)
            ST_RESET:
            begin
                // straps are still crossing the synchroniser here
                st_next = ST_WAIT;
            end
            ST_WAIT:
            begin
                mode_next = pin2_reg[3:2];
                wid_next  = pin2_reg[1:0];
                if (wcnt_reg == '0)
                    wcnt_next = WW'(1);
                else
                begin
                    wcnt_next = '0;
                    if (pin2_reg[3:2] == MODE_ROM)
                        st_next = ST_COPY;
                    else
                        st_next = ST_STALL;
                end
            end
            ST_STALL:
            begin
                // host and emulation modes wait for the doorbell
                if (db_event && mode_reg != MODE_ROM)
                begin
                    st_next    = ST_RUN;
                    start_next = 1'b1;
                end
            end
            ST_COPY:
            begin
                if (pk_valid)
                    wcnt_next = WW'(wcnt_reg + 1'b1);
                if (pk_valid && wcnt_reg == WW'(WORDS - 1))
                begin
                    st_next    = ST_RUN;
                    start_next = 1'b1;
                end
            end
            ST_RUN:
            begin
                // doorbells while running interrupt the cpu
                if (db_event)
                    irq_next = 1'b1;
            end
            default: st_next = ST_RESET;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg    <= ST_RESET;
            mode_reg  <= MODE_HOST;
            wid_reg   <= ROM_W8;
            db_reg    <= 1'b0;
            irq_reg   <= 1'b0;
            wcnt_reg  <= '0;
            start_reg <= 1'b0;
        end
        else
        begin
            st_reg    <= st_next;
            mode_reg  <= mode_next;
            wid_reg   <= wid_next;
            db_reg    <= db_next;
            irq_reg   <= irq_next;
            wcnt_reg  <= wcnt_next;
            start_reg <= start_next;
        end
    end

    rom_word_packer u_packer (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .clear      (st_reg != ST_COPY),
        .rom_width  (wid_reg),
        .beat_valid (rom_beat_valid && copy_ready && st_reg == ST_COPY),
        .beat_data  (rom_beat_data),
        .word_valid (pk_valid),
        .word_data  (pk_data)
    );

    // =========================================================
    // outputs
    assign periph_rst_n     = rst_n;
    assign cpu_stall        = (st_reg != ST_RUN);
    assign cpu_start        = start_reg;
    assign cpu_start_addr   = CPU_START_ADDR;
    assign host_doorbell    = db_reg;
    assign cpu_doorbell_irq = irq_reg;
    // host keeps port access after boot too
    assign host_mem_grant   = host_mem_req && rst_n;
    assign copy_req         = (st_reg == ST_COPY);
    assign copy_src_addr    = ROM_BASE_ADDR;
    assign copy_dst_addr    = COPY_DST_ADDR;
    assign copy_word        = pk_data;
    assign copy_word_valid  = pk_valid;
    assign latched_mode     = mode_reg;

    // =========================================================
    // checks
    property p_stall_rst;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(rst_n) |-> cpu_stall;
    endproperty
    a_stall_rst: assert property (p_stall_rst)
        else $error("cpu not stalled after reset");

    property p_host_release;
        @(posedge core_clk) disable iff (!rst_n)
        (st_reg == ST_STALL && db_event && mode_reg == MODE_HOST)
            |=> !cpu_stall && cpu_start;
    endproperty
    a_host_release: assert property (p_host_release)
        else $error("doorbell did not release cpu");

    property p_no_irq_boot;
        @(posedge core_clk) disable iff (!rst_n)
        cpu_stall |=> !$rose(cpu_doorbell_irq);
    endproperty
    a_no_irq_boot: assert property (p_no_irq_boot)
        else $error("boot doorbell raised irq");

    property p_rom_ignores_db;
        @(posedge core_clk) disable iff (!rst_n)
        (st_reg == ST_COPY && !pk_valid) |=> cpu_stall;
    endproperty
    a_rom_ignores_db: assert property (p_rom_ignores_db)
        else $error("rom boot released early");

    property p_db_hold;
        @(posedge core_clk) disable iff (!rst_n)
        (db_reg && !cpu_doorbell_clear) |=> db_reg;
    endproperty
    a_db_hold: assert property (p_db_hold)
        else $error("doorbell lost before clear");

    property p_mode_stable;
        @(posedge core_clk) disable iff (!rst_n)
        (st_reg == ST_RUN || st_reg == ST_STALL || st_reg == ST_COPY)
            |=> $stable(mode_reg);
    endproperty
    a_mode_stable: assert property (p_mode_stable)
        else $error("boot mode changed");

    property p_start_addr;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(cpu_stall) |-> cpu_start && cpu_start_addr == 32'h0;
    endproperty
    a_start_addr: assert property (p_start_addr)
        else $error("start not at zero");

    property p_periph_run;
        @(posedge core_clk)
        !rst_n |-> !periph_rst_n && cpu_stall && !cpu_start && !host_doorbell;
    endproperty
    a_periph_run: assert property (p_periph_run)
        else $error("peripherals out of reset early");

endmodule : boot_stall_ctrl

//--- bench/host_model.sv
// host port partner: rings the doorbell and makes memory requests
// assumes the bench calls its tasks; drives just after the rising edge
`timescale 1ns/10ps
module host_model
(
    input  wire logic core_clk,
    input  wire logic host_mem_grant,
    output logic      host_doorbell_set,
    output logic      host_mem_req
);
    // =========================================================
    // idle levels
    initial
    begin
        host_doorbell_set = 1'b0;
        host_mem_req      = 1'b0;
    end

    // =========================================================
    // doorbell: one-cycle set pulse once loading is finished
    task automatic ring();
        @(posedge core_clk);
        host_doorbell_set <= 1'b1;
        @(posedge core_clk);
        host_doorbell_set <= 1'b0;
    endtask : ring

    // request held until grant is seen at an edge, no sooner, for at most 8 edges
    task automatic access(output logic ok);
        int i;
        ok = 1'b0;
        @(posedge core_clk);
        host_mem_req <= 1'b1;
        for (i = 0; i < 8 && ok !== 1'b1; i++)
        begin
            @(posedge core_clk);
            ok = host_mem_grant;
        end
        host_mem_req <= 1'b0;
    endtask : access
endmodule : host_model

//--- bench/tb.sv
// self-checking bench for the reset and boot stall controller
// assumes the package and host_model are compiled before it
`timescale 1ns/10ps
module tb
    import boot_ctrl_pkg::*;
;
    logic        core_clk, arst_n, cpu_doorbell_clear, emu_doorbell_set;
    logic [1:0]  boot_mode_pin, rom_width_pin, latched_mode;
    logic        copy_ready, rom_beat_valid, host_doorbell_set;
    logic        host_mem_req, periph_rst_n, cpu_stall, cpu_start;
    logic        host_doorbell, cpu_doorbell_irq, host_mem_grant;
    logic        copy_req, copy_word_valid;
    logic [31:0] rom_beat_data, cpu_start_addr, copy_src_addr;
    logic [31:0] copy_dst_addr, copy_word;
    logic [31:0] got [0:7];
    int          n_words, n_fail, cmp_count;

    // short copy keeps the run brief
    boot_stall_ctrl #(.COPY_BYTES(16)) dut (.core_clk(core_clk),
        .arst_n(arst_n), .boot_mode_pin(boot_mode_pin),
        .rom_width_pin(rom_width_pin),
        .host_doorbell_set(host_doorbell_set),
        .cpu_doorbell_clear(cpu_doorbell_clear),
        .host_mem_req(host_mem_req), .emu_doorbell_set(emu_doorbell_set),
        .copy_ready(copy_ready), .rom_beat_valid(rom_beat_valid),
        .rom_beat_data(rom_beat_data), .periph_rst_n(periph_rst_n),
        .cpu_stall(cpu_stall), .cpu_start(cpu_start),
        .cpu_start_addr(cpu_start_addr), .host_doorbell(host_doorbell),
        .cpu_doorbell_irq(cpu_doorbell_irq),
        .host_mem_grant(host_mem_grant), .copy_req(copy_req),
        .copy_src_addr(copy_src_addr), .copy_dst_addr(copy_dst_addr),
        .copy_word(copy_word), .copy_word_valid(copy_word_valid),
        .latched_mode(latched_mode));

    host_model host (.core_clk(core_clk), .host_mem_grant(host_mem_grant),
        .host_doorbell_set(host_doorbell_set), .host_mem_req(host_mem_req));

    // =========================================================
    // clock, word capture and compares
    initial core_clk = 1'b0;
    always #10 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        if (copy_word_valid === 1'b1 && n_words < 8)
        begin
            got[n_words] = copy_word;
            n_words++;
        end
    end

    task automatic check_bit(input logic g, input logic e);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: bit got %b exp %b", $time, g, e);
        end
    endtask : check_bit

    task automatic check_word(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value at %0t: word got %h exp %h", $time, g, e);
        end
    endtask : check_word

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : summarize

    // bounded wait: 0 start pulse, 1 copy running, 2 cpu freed
    task automatic wait_on(input int sel);
        int  i;
        logic hit;
        hit = 1'b0;
        for (i = 0; i < 64 && !hit; i++)
        begin
            #1;
            hit = (sel == 0) ? (cpu_start === 1'b1) :
                  (sel == 1) ? (copy_req === 1'b1) : (cpu_stall === 1'b0);
            if (!hit)
                @(posedge core_clk);
        end
        if (!hit)
        begin
            n_fail++;
            $display("wrong value at %0t: wait %0d ran out", $time, sel);
            summarize();
        end
    endtask : wait_on

    // =========================================================
    // scenarios
    task automatic do_reset(input logic [1:0] m, input logic [1:0] w);
        @(posedge core_clk);
        arst_n        <= 1'b0;
        boot_mode_pin <= m;
        rom_width_pin <= w;
        repeat (2) @(posedge core_clk);
        #1;
        check_bit(cpu_stall, 1'b1);
        check_bit(periph_rst_n, 1'b0);
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (10) @(posedge core_clk);
        #1;
        check_bit(periph_rst_n, 1'b1);
        check_bit(cpu_stall, 1'b1);
        check_word({30'h0, latched_mode}, {30'h0, m});
    endtask : do_reset

    task automatic test_host();
        logic ok;
        do_reset(MODE_HOST, ROM_W32);
        host.access(ok);
        check_bit(ok, 1'b1);
        host.access(ok);
        check_bit(ok, 1'b1);
        boot_mode_pin <= MODE_ROM;
        host.ring();
        wait_on(0);
        check_bit(cpu_stall, 1'b0);
        check_word(cpu_start_addr, CPU_START_ADDR);
        check_word({30'h0, latched_mode}, {30'h0, MODE_HOST});
        check_bit(cpu_doorbell_irq, 1'b0);
        @(posedge core_clk);
        #1;
        check_bit(cpu_start, 1'b0);
        host.ring();
        repeat (2) @(posedge core_clk);
        #1;
        check_bit(cpu_doorbell_irq, 1'b0);
        @(posedge core_clk);
        cpu_doorbell_clear <= 1'b1;
        @(posedge core_clk);
        cpu_doorbell_clear <= 1'b0;
        @(posedge core_clk);
        #1;
        check_bit(host_doorbell, 1'b0);
        host.ring();
        repeat (2) @(posedge core_clk);
        #1;
        check_bit(cpu_doorbell_irq, 1'b1);
        $display("test host done");
    endtask : test_host

    task automatic test_rom(input logic [1:0] w);
        int i, k, bpb;
        logic [31:0] d;
        bpb = (w == ROM_W8) ? 1 : (w == ROM_W16) ? 2 : 4;
        do_reset(MODE_ROM, w);
        n_words = 0;
        host.ring();
        repeat (2) @(posedge core_clk);
        #1;
        check_bit(cpu_stall, 1'b1);
        wait_on(1);
        check_word(copy_src_addr, ROM_BASE_ADDR);
        check_word(copy_dst_addr, COPY_DST_ADDR);
        // a beat offered while the engine is busy must not land
        @(posedge core_clk);
        copy_ready     <= 1'b0;
        rom_beat_valid <= 1'b1;
        rom_beat_data  <= 32'hDEAD_BEEF;
        // upper lanes of narrow beats carry junk that must be dropped
        for (i = 0; i < 16 / bpb; i++)
        begin
            @(posedge core_clk);
            d = 32'hEEEE_EEEE;
            copy_ready <= 1'b1;
            for (k = 0; k < bpb; k++)
                d[8*k +: 8] = 8'h30 + 8'(i * bpb + k);
            rom_beat_valid <= 1'b1;
            rom_beat_data  <= d;
        end
        @(posedge core_clk);
        rom_beat_valid <= 1'b0;
        wait_on(2);
        check_word(cpu_start_addr, CPU_START_ADDR);
        check_word(32'(n_words), 32'h4);
        for (i = 0; i < 4; i++)
        begin
            for (k = 0; k < 4; k++)
                d[8*k +: 8] = 8'h30 + 8'(4 * i + k);
            check_word(got[i], d);
        end
        $display("test rom width %0d done", w);
    endtask : test_rom

    task automatic test_emu();
        do_reset(MODE_EMU, ROM_W32);
        @(posedge core_clk);
        emu_doorbell_set <= 1'b1;
        wait_on(0);
        check_bit(cpu_stall, 1'b0);
        check_bit(host_doorbell, 1'b1);
        check_word(cpu_start_addr, CPU_START_ADDR);
        @(posedge core_clk);
        emu_doorbell_set <= 1'b0;
        $display("test emu done");
    endtask : test_emu

    initial
    begin
        arst_n             = 1'b0;
        boot_mode_pin      = MODE_HOST;
        rom_width_pin      = ROM_W32;
        cpu_doorbell_clear = 1'b0;
        emu_doorbell_set   = 1'b0;
        copy_ready         = 1'b1;
        rom_beat_valid     = 1'b0;
        rom_beat_data      = 32'h0;
        n_words = 0;
        n_fail = 0;
        cmp_count = 0;
        test_host();
        test_rom(ROM_W8);
        test_rom(ROM_W16);
        test_rom(ROM_W32);
        test_emu();
        summarize();
    end
endmodule : tb
